// ==== verilog/sadp_pkg.sv ====
// Shared constants and types of the dual-mode serial converter port.
`default_nettype none

package sadp_pkg;

    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    localparam int SADP_RES_W = 10;
    localparam int SADP_CNT_W = 5;
    localparam logic [4:0] SADP_FIRST_BIT = 5'h01;
    localparam logic [4:0] SADP_ZERO_BITS = 5'h06;
    localparam logic [4:0] SADP_WORD_BITS = 5'h10;
    localparam logic [4:0] SADP_TRI_EDGE = 5'h11;
    localparam logic [4:0] SADP_CNT_RST = 5'h00;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic SADP_PD_RST = 1'b1;
    localparam logic SADP_OE_RST = 1'b0;
    localparam logic [9:0] SADP_RES_RST = 10'h000;

    // ------------------------------------------------------------------
    // Host-side timing, kept for reference by the far side only
    // ------------------------------------------------------------------
    localparam int SADP_BURST_GAP_US = 100;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SADP_IDLE = 4'b0001,
        SADP_DECIDE = 4'b0010,
        SADP_DSP = 4'b0100,
        SADP_UC = 4'b1000
    } sadp_mode_t;

    // Pin levels that arrive from outside the system clock domain.
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic frame_sync;
    } sadp_pins_t;

    // Idle pin levels: deselected, serial clock low, frame sync low.
    // The synchroniser and edge detectors reset to these so no false edge follows reset.
    localparam sadp_pins_t SADP_PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, frame_sync: 1'b0};

endpackage : sadp_pkg

`default_nettype wire

// ==== verilog/sadp_sync.sv ====
// Two-flop synchroniser for the port's asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none

module sadp_sync import sadp_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire sadp_pins_t pins_i,
    output var sadp_pins_t pins_o
);

    // ------------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------------
    sadp_pins_t meta_q;

    // Idle pin levels are used as reset values so no false edge is seen.
    // The first stage feeds only the second stage.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= SADP_PINS_IDLE;
            pins_o <= SADP_PINS_IDLE;
        end else begin
            meta_q <= pins_i;
            pins_o <= meta_q;
        end
    end

endmodule : sadp_sync

`default_nettype wire

// ==== verilog/sadp_port.sv ====
// Serial output port and conversion sequencer of the dual-mode converter.
//
// How it works
// - Chip-select fall samples frame sync: low means DSP mode, high means microcontroller mode only if the second capture agrees.
// - Frame sync captured twice; microcontroller mode only when both captures read one.
// - Chip select high tri-states the data pin and forces full powerdown.
// - After chip select falls in DSP mode, every serial clock fall checks frame sync.
// - In DSP mode the device stays powered down until frame sync is high.
// - Frame sync high at a clock fall resets the sequencer; then first zero follows.
// - DSP sampling spans from the fall after frame sync to sixth zero bit.
// - Each word is six zeros then the result, bits driven on rising edges.
// - DSP mode powers down at the seventeenth fall; frame sync wakes it.
// - DSP data pin floats at the seventeenth rise, driven again at frame sync rise.
// - Frame sync during bit sixteen starts the next word on the next rise.
// - Frame sync high mid-word aborts it and starts a fresh conversion.
// - A frame sync pulse that spans no serial clock fall only re-drives the data pin in DSP mode.
// - Microcontroller sampling starts on the first rise after chip select falls.
// - Microcontroller result driven on rises after six zeros, captured on falls.
// - Microcontroller mode powers down at the sixteenth fall, wakes at the next rise.
// - Short transfers end by raising chip select; each fall restarts the device.
`timescale 1ns/1ps
`default_nettype none

module sadp_port import sadp_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic frame_sync_i,
    input wire logic [9:0] adc_result_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic powerdown_o,
    output logic sampling_o,
    output logic uc_mode_o
);

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    sadp_pins_t pins_async;
    sadp_pins_t pins_s;
    logic sclk_q;
    logic fs_q;
    logic sclk_rise;
    logic sclk_fall;
    logic fs_rise;

    assign pins_async = '{cs_n: cs_n_i, sclk: sclk_i, frame_sync: frame_sync_i};

    sadp_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .pins_i(pins_async),
        .pins_o(pins_s)
    );

    // Previous synchronised levels, used only to find edges.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= SADP_PINS_IDLE.sclk;
            fs_q <= SADP_PINS_IDLE.frame_sync;
        end else begin
            sclk_q <= pins_s.sclk;
            fs_q <= pins_s.frame_sync;
        end
    end

    // The serial clock is oversampled, so its period must exceed about four system clocks.
    assign sclk_rise = pins_s.sclk & ~sclk_q;
    assign sclk_fall = ~pins_s.sclk & sclk_q;
    assign fs_rise = pins_s.frame_sync & ~fs_q;

    // ------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------
    sadp_mode_t mode_q;
    logic fs_cap_q;
    logic in_dsp;
    logic in_uc;

    // The first capture is taken on the cycle chip select is seen low, the second one cycle later.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= SADP_IDLE;
            fs_cap_q <= 1'b0;
        end else if (pins_s.cs_n) begin
            mode_q <= SADP_IDLE;
        end else begin
            unique case (mode_q)
                SADP_IDLE: begin
                    fs_cap_q <= pins_s.frame_sync;
                    mode_q <= SADP_DECIDE;
                end
                SADP_DECIDE: begin
                    // A glitch that spoils either capture falls back to DSP mode.
                    if (fs_cap_q && pins_s.frame_sync) begin
                        mode_q <= SADP_UC;
                    end else begin
                        mode_q <= SADP_DSP;
                    end
                end
                SADP_DSP: mode_q <= SADP_DSP;
                SADP_UC: mode_q <= SADP_UC;
                default: mode_q <= SADP_IDLE;
            endcase
        end
    end

    // Chip select high overrides the mode at once, before the state has returned to idle.
    assign in_dsp = (mode_q == SADP_DSP) && !pins_s.cs_n;
    assign in_uc = (mode_q == SADP_UC) && !pins_s.cs_n;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            uc_mode_o <= 1'b0;
        end else begin
            uc_mode_o <= in_uc;
        end
    end

    // ------------------------------------------------------------------
    // Bit sequencer
    // ------------------------------------------------------------------
    logic [4:0] cnt_q;
    logic go_q;
    logic fs_reset;
    logic rise_act;
    logic [4:0] next_idx;

    // Frame sync is checked only at serial clock falls in DSP mode.
    assign fs_reset = in_dsp && sclk_fall && pins_s.frame_sync;
    assign rise_act = sclk_rise && (in_uc || (in_dsp && go_q));
    // In microcontroller mode the rise after bit sixteen opens the next word.
    assign next_idx = (in_uc && cnt_q == SADP_WORD_BITS) ? SADP_FIRST_BIT : 5'(cnt_q + SADP_FIRST_BIT);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= SADP_CNT_RST;
            go_q <= 1'b0;
        end else if (!(in_dsp || in_uc)) begin
            cnt_q <= SADP_CNT_RST;
            go_q <= 1'b0;
        end else if (fs_reset) begin
            // A frame sync during bit sixteen lands here too, so the next rise is bit one.
            cnt_q <= SADP_CNT_RST;
            go_q <= 1'b1;
        end else if (rise_act) begin
            cnt_q <= next_idx;
            if (in_dsp && next_idx == SADP_TRI_EDGE) begin
                go_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial data and result shifter
    // ------------------------------------------------------------------
    logic [9:0] res_q;

    // Bit value for a given position; zero padding precedes the result.
    function automatic logic sadp_bit_val(input logic [4:0] idx, input logic msb);
        sadp_bit_val = (idx > SADP_ZERO_BITS && idx <= SADP_WORD_BITS) ? msb : 1'b0;
    endfunction : sadp_bit_val

    // The result is taken when sampling ends so it is stable for the whole shift.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_q <= SADP_RES_RST;
            sdo_o <= 1'b0;
        end else if (rise_act) begin
            sdo_o <= sadp_bit_val(next_idx, res_q[SADP_RES_W - 1]);
            if (next_idx == SADP_ZERO_BITS) begin
                res_q <= adc_result_i;
            end else if (next_idx > SADP_ZERO_BITS) begin
                res_q <= {res_q[SADP_RES_W - 2:0], 1'b0};
            end
        end else if (!(in_dsp || in_uc)) begin
            sdo_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Output enable
    // ------------------------------------------------------------------
    // The frame sync rise wins over the tri-state edge if both coincide.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdo_oe_o <= SADP_OE_RST;
        end else if (pins_s.cs_n) begin
            sdo_oe_o <= 1'b0;
        end else if (mode_q == SADP_DECIDE) begin
            sdo_oe_o <= 1'b1;
        end else if (in_dsp && fs_rise) begin
            sdo_oe_o <= 1'b1;
        end else if (in_dsp && rise_act && next_idx == SADP_TRI_EDGE) begin
            sdo_oe_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            powerdown_o <= SADP_PD_RST;
        end else if (!(in_dsp || in_uc)) begin
            powerdown_o <= 1'b1;
        end else if (fs_reset) begin
            powerdown_o <= 1'b0;
        end else if (in_dsp && sclk_fall && go_q && cnt_q == SADP_WORD_BITS) begin
            powerdown_o <= 1'b1;
        end else if (in_uc && sclk_rise) begin
            powerdown_o <= 1'b0;
        end else if (in_uc && sclk_fall && cnt_q == SADP_WORD_BITS) begin
            powerdown_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Sampling window
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sampling_o <= 1'b0;
        end else if (!(in_dsp || in_uc) || fs_reset) begin
            sampling_o <= 1'b0;
        end else if (in_dsp && sclk_fall && go_q && cnt_q < SADP_ZERO_BITS) begin
            sampling_o <= 1'b1;
        end else if (rise_act && next_idx == SADP_ZERO_BITS) begin
            sampling_o <= 1'b0;
        end else if (in_uc && sclk_rise && next_idx == SADP_FIRST_BIT) begin
            sampling_o <= 1'b1;
        end
    end

endmodule : sadp_port

`default_nettype wire

// ==== verification/sadp_port_asserts.sv ====
// Concurrent checks on the ports of the dual-mode converter port.
`timescale 1ns/1ps
`default_nettype none
module sadp_port_asserts (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic frame_sync_i,
    input wire logic [9:0] adc_result_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic powerdown_o,
    input wire logic sampling_o,
    input wire logic uc_mode_o
);
    // ------
    // Port checks
    // ------
    // Pins cross a synchroniser, so the windows allow a few cycles of slack.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_idle; cs_n_i [*7] |-> !sdo_oe_o && powerdown_o && !sampling_o && !uc_mode_o; endproperty
    a_idle: assert property (p_idle) else $error("port active while deselected");
    property p_uc_cause; $rose(uc_mode_o) |-> frame_sync_i && !cs_n_i; endproperty
    a_uc_cause: assert property (p_uc_cause) else $error("uc mode without frame sync high");
    property p_dsp_mode; $fell(cs_n_i) && !frame_sync_i |-> !uc_mode_o [*8]; endproperty
    a_dsp_mode: assert property (p_dsp_mode) else $error("uc mode with frame sync low");
    property p_uc_enter; $fell(cs_n_i) && frame_sync_i ##1 frame_sync_i [*6] |-> ##[0:3] uc_mode_o; endproperty
    a_uc_enter: assert property (p_uc_enter) else $error("uc mode not entered");
    property p_oe_on; $fell(cs_n_i) |-> ##[3:8] sdo_oe_o; endproperty
    a_oe_on: assert property (p_oe_on) else $error("data pin not driven after select");
    property p_pd_hold; $fell(cs_n_i) && !frame_sync_i ##1 !frame_sync_i [*8] |-> powerdown_o; endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("woke before frame sync");
    property p_wake; $fell(sclk_i) && frame_sync_i && !cs_n_i && !uc_mode_o |-> ##[2:6] !powerdown_o; endproperty
    a_wake: assert property (p_wake) else $error("frame sync did not wake port");
    property p_oe_drop; $fell(sdo_oe_o) && !cs_n_i |-> powerdown_o; endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("data pin released before powerdown");
    property p_samp_pd; sampling_o |-> !powerdown_o; endproperty
    a_samp_pd: assert property (p_samp_pd) else $error("sampling while powered down");
    property p_samp_zero; sampling_o |-> !sdo_o; endproperty
    a_samp_zero: assert property (p_samp_zero) else $error("nonzero bit while sampling");
    c_uc: cover property ($rose(uc_mode_o));
    c_wake: cover property ($fell(powerdown_o));
    c_tri: cover property ($fell(sdo_oe_o) && !cs_n_i);
endmodule : sadp_port_asserts
bind sadp_port sadp_port_asserts i_asserts (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
    .sclk_i(sclk_i), .frame_sync_i(frame_sync_i), .adc_result_i(adc_result_i), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .powerdown_o(powerdown_o), .sampling_o(sampling_o), .uc_mode_o(uc_mode_o));
`default_nettype wire

// ==== verification/sadp_host_model.sv ====
// Behavioural host that clocks the port as a DSP serial port or an SPI master.
`timescale 1ns/1ps
`default_nettype none
module sadp_host_model (
    input wire logic sys_clk_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    input wire logic sampling_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic frame_sync_o
);
    // ------
    // Host pins
    // ------
    logic last_q = 1'b0;
    logic line_w;
    // A released pin shows the inverse of the last bit, so stale data never passes.
    assign line_w = sdo_oe_i ? sdo_i : ~last_q;
    // Idle levels at time zero: deselected, clock low.
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        frame_sync_o = 1'b0;
    end
    task automatic ticks(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : ticks
    // Frame sync takes the first level at the select edge and the second one clock later; a differing second level models a glitch.
    task automatic select(input logic fs1, input logic fs2);
        frame_sync_o = fs1;
        cs_n_o = 1'b0;
        ticks(1);
        frame_sync_o = fs2;
        ticks(11);
    endtask : select
    task automatic release_cs();
        cs_n_o = 1'b1;
        ticks(12);
    endtask : release_cs
    // Runs n clocks of 160 ns, capturing at each fall; optional frame sync pulse at the last fall.
    task automatic cycles(input int n, input logic fs_last, output logic [15:0] word, output logic [1:0] samp);
        word = 16'h0000;
        samp = 2'b00;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b1;
            ticks(4);
            if (fs_last && i == n - 1) frame_sync_o = 1'b1;
            ticks(4);
            word = {word[14:0], line_w};
            last_q = line_w;
            if (i == 1) samp[1] = sampling_i;
            if (i == 7) samp[0] = sampling_i;
            sclk_o = 1'b0;
            ticks(4);
            if (fs_last && i == n - 1) frame_sync_o = 1'b0;
            ticks(4);
        end
    endtask : cycles
endmodule : sadp_host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the dual-mode converter port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ------
    // Bench
    // ------
    logic sys_clk = 1'b0;
    logic rst_n, cs_n, sclk, fs, sdo, oe, pd, samp, uc;
    logic [9:0] adc;
    logic [15:0] w;
    logic [1:0] s;
    int fails = 0;
    int tests_run = 0;
    always #5 sys_clk = ~sys_clk;
    sadp_port i_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk), .frame_sync_i(fs),
        .adc_result_i(adc), .sdo_o(sdo), .sdo_oe_o(oe), .powerdown_o(pd), .sampling_o(samp), .uc_mode_o(uc));
    sadp_host_model i_host (.sys_clk_i(sys_clk), .sdo_i(sdo), .sdo_oe_i(oe), .sampling_i(samp),
        .cs_n_o(cs_n), .sclk_o(sclk), .frame_sync_o(fs));
    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_word
    // Flags are compared as drive enable, powerdown, microcontroller mode.
    task automatic check_flags(input logic [2:0] exp);
        tests_run++;
        if ({oe, pd, uc} !== exp) begin
            fails++;
            $display("unexpected flags: expected %b, seen %b", exp, {oe, pd, uc});
        end
    endtask : check_flags
    // A truncated word keeps the first n bits: zeros, then result MSB first.
    task automatic xfer(input int n, input logic fs_last, input logic [9:0] res);
        adc = res;
        i_host.cycles(n, fs_last, w, s);
        check_word("word", {6'h00, res} >> (16 - n), w);
        if (n >= 8) check_word("sampling", 16'h0002, {14'h0000, s});
    endtask : xfer
    task automatic t_dsp();
        i_host.select(1'b0, 1'b0);
        check_flags(3'b110);
        i_host.cycles(1, 1'b1, w, s);
        i_host.ticks(4);
        check_flags(3'b100);
        xfer(16, 1'b0, 10'h2A5);
        i_host.ticks(4);
        check_flags(3'b110);
        i_host.cycles(1, 1'b0, w, s);
        check_flags(3'b010);
        i_host.cycles(1, 1'b1, w, s);
        i_host.ticks(4);
        check_flags(3'b100);
        xfer(16, 1'b1, 10'h15A);
        i_host.ticks(4);
        check_flags(3'b100);
        xfer(16, 1'b0, 10'h0F3);
        i_host.cycles(1, 1'b1, w, s);
        xfer(9, 1'b1, 10'h3C1);
        xfer(16, 1'b0, 10'h1E7);
        i_host.release_cs();
        check_flags(3'b010);
        i_host.select(1'b1, 1'b0);
        check_flags(3'b110);
        i_host.release_cs();
    endtask : t_dsp
    task automatic t_uc();
        logic [7:0] hi;
        i_host.select(1'b1, 1'b1);
        check_flags(3'b111);
        xfer(16, 1'b0, 10'h3FF);
        i_host.ticks(4);
        check_flags(3'b111);
        i_host.cycles(1, 1'b0, w, s);
        check_flags(3'b101);
        i_host.release_cs();
        check_flags(3'b010);
        i_host.select(1'b1, 1'b1);
        adc = 10'h1C6;
        i_host.cycles(8, 1'b0, w, s);
        hi = w[7:0];
        i_host.ticks(200);
        i_host.cycles(8, 1'b0, w, s);
        check_word("burst word", 16'h01C6, {hi, w[7:0]});
        i_host.release_cs();
        i_host.select(1'b1, 1'b1);
        xfer(8, 1'b0, 10'h2D3);
        i_host.release_cs();
        i_host.select(1'b1, 1'b1);
        xfer(16, 1'b0, 10'h0B5);
        i_host.release_cs();
    endtask : t_uc
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    // Main sequence: reset for 16 cycles, then DSP and microcontroller traffic.
    initial begin
        rst_n = 1'b0;
        adc = 10'h000;
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        i_host.ticks(2);
        check_flags(3'b010);
        t_dsp();
        t_uc();
        complete_run();
    end
    // Watchdog cuts a hang short.
    initial begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        $display("unexpected run length: expected under 100000 cycles, seen more");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
